// >>> rtl/u9m_ctrl.sv
// Nine-bit multidrop control for the second serial port, with its APB register file.
// Assumes the UART core supplies received characters, transmit status and a bit-time strobe.
module u9m_ctrl
  import u9m_pkg::*;
(
  input  wire logic          clk_sys,          // 25 MHz clock
  input  wire logic          nrst,             // Async reset, active low
  input  wire logic          ce,               // Clock enable, freezes state when low
  input  wire logic          psel,             // APB select
  input  wire logic          penable,          // APB access phase
  input  wire logic          pwrite,           // APB write
  input  wire logic [11:0]   paddr,            // APB byte address
  input  wire logic [31:0]   pwdata,           // APB write data
  output logic      [31:0]   prdata,           // APB read data
  output logic               pready,           // APB ready
  output logic               pslverr,          // APB error on unmapped address
  input  wire logic          rx_valid,         // Received character strobe
  input  wire u9m_char_t     rx_char,          // Received character with ninth bit
  output u9m_char_t          rxf_char,         // Character to receive FIFO
  output logic               rxf_wr,           // Receive FIFO write pulse
  input  wire logic          tx_start,         // Core loads a character
  input  wire logic          tx_busy,          // Core transmitter busy
  input  wire logic          tx_done,          // Character fully sent pulse
  input  wire logic          bit_tick,         // One bit-time strobe
  output logic               tx_ninth,         // Ninth bit for the transmitter
  output logic               tx_ninth_en,      // Parity slot carries address/data mark
  input  wire logic          rts_core,         // Modem-control RTS level from core
  output logic               rts_out,          // RTS pin level
  input  wire logic          err_orig,         // Original receive FIFO error indication
  input  wire logic          err_new,          // Revised receive FIFO error indication
  output logic               rx_err,           // Selected receive FIFO error indication
  input  wire logic          core_irq,         // Base UART interrupt request
  output logic               port_irq,         // Port interrupt line
  output logic               rx_clk_delay,     // Delay receive sample clock by 5 ns
  output logic [1:0]         baud_clk_sel      // Baud clock source select
);

  logic [7:0] misc_q, cfg_q, slave_q, mask_q, bcast_q;
  logic [1:0] irqc_q;
  logic       stat_q, send_addr_q, accept_q, irq_src_q;
  logic       tx_addr_q;
  logic [1:0] hold_q;
  u9m_dir_t   dir_q;

  // APB decode; the slave answers without wait states while ce is high, since pready follows ce
  logic [9:0] idx;
  logic       aligned, mapped, wr_en, setup;
  assign idx     = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  always_comb begin
    unique case (idx)
      IDX_MISC, IDX_TXRX, IDX_CFG, IDX_SLAVE, IDX_MASK, IDX_BCAST, IDX_IRQC, IDX_STAT:
        mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end
  assign setup   = ce & psel & ~penable;
  assign wr_en   = ce & psel & penable & pwrite & mapped;
  assign pready  = ce;
  assign pslverr = psel & penable & ~mapped;

  function automatic logic wr_hit(input logic [9:0] which);
    wr_hit = wr_en & (idx == which);
  endfunction

  // Read data is captured in the setup cycle so it comes from a flip-flop
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= 32'h0000_0000;
      if (!pwrite && mapped) begin
        unique case (idx)
          IDX_MISC:  prdata[7:0] <= misc_q;
          IDX_TXRX:  prdata[1:0] <= {accept_q, send_addr_q};
          IDX_CFG:   prdata[7:0] <= cfg_q;
          IDX_SLAVE: prdata[7:0] <= slave_q;
          IDX_MASK:  prdata[7:0] <= mask_q;
          IDX_BCAST: prdata[7:0] <= bcast_q;
          IDX_IRQC:  prdata[1:0] <= irqc_q;
          default:   prdata[0]   <= stat_q;
        endcase
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      misc_q  <= RST_MISC;
      cfg_q   <= RST_CFG;
      slave_q <= RST_SLAVE;
      mask_q  <= RST_MASK;
      bcast_q <= RST_BCAST;
      irqc_q  <= RST_IRQC;
    end else begin
      if (wr_hit(IDX_MISC))  misc_q  <= pwdata[7:0] & MISC_WMASK;
      if (wr_hit(IDX_CFG))   cfg_q   <= pwdata[7:0];
      if (wr_hit(IDX_SLAVE)) slave_q <= pwdata[7:0];
      if (wr_hit(IDX_MASK))  mask_q  <= pwdata[7:0];
      if (wr_hit(IDX_BCAST)) bcast_q <= pwdata[7:0];
      if (wr_hit(IDX_IRQC))  irqc_q  <= pwdata[1:0];
    end
  end

  // Static steering from the miscellaneous register
  assign rx_clk_delay = ~misc_q[MISC_NODELAY];
  assign baud_clk_sel = misc_q[1:0];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_err <= 1'b0;
    end else if (ce) begin
      rx_err <= misc_q[MISC_NEWERR] ? err_new : err_orig;
    end
  end

  // Receive address filter
  logic nine, is_addr, match, irq_evt, pass_data, store_addr;
  assign nine       = cfg_q[CFG_NINE];
  assign is_addr    = nine & rx_char.ninth;
  assign match      = (rx_char.data == bcast_q) |
                      (((rx_char.data ^ slave_q) & mask_q) == 8'h00);
  assign pass_data  = ~is_addr & (~nine | ~cfg_q[CFG_AUTO_RX] | accept_q);
  assign store_addr = is_addr & cfg_q[CFG_STORE];
  assign irq_evt    = ce & rx_valid & is_addr & cfg_q[CFG_AUTO_RX] &
                      (~irqc_q[IRQC_MATCH] | match) & irqc_q[IRQC_EN];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxf_wr   <= 1'b0;
      rxf_char <= '0;
    end else if (ce) begin
      rxf_wr <= rx_valid & (pass_data | store_addr);
      if (rx_valid) rxf_char <= rx_char;
    end
  end

  // Accept flag: hardware update overrides a simultaneous software write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      accept_q <= 1'b0;
    end else if (ce && rx_valid && is_addr && cfg_q[CFG_AUTO_RX] && !cfg_q[CFG_CMP_ONLY]) begin
      accept_q <= match;
    end else if (wr_hit(IDX_TXRX)) begin
      accept_q <= pwdata[TXRX_ACCEPT];
    end
  end

  // Send-address flag; the hardware clear wins over a same-cycle software write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_addr_q <= 1'b0;
    end else if (ce && tx_start) begin
      tx_addr_q <= nine & send_addr_q;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      send_addr_q <= 1'b0;
    end else if (ce && tx_done && tx_addr_q && cfg_q[CFG_AUTO_TX]) begin
      send_addr_q <= 1'b0;
    end else if (wr_hit(IDX_TXRX)) begin
      send_addr_q <= pwdata[TXRX_SENDADR];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_ninth    <= 1'b0;
      tx_ninth_en <= 1'b0;
    end else if (ce) begin
      tx_ninth_en <= nine;
      tx_ninth    <= nine & send_addr_q;
    end
  end

  // Automatic RS-485 direction: drive while sending, hold 1 or 2 bit times after
  logic auto_dir;
  assign auto_dir = nine & cfg_q[CFG_RS485];
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dir_q  <= DIR_IDLE;
      hold_q <= 2'h0;
    end else if (ce) begin
      unique case (dir_q)
        DIR_IDLE: if (auto_dir && tx_busy) dir_q <= DIR_SEND;
        DIR_SEND: begin
          if (!tx_busy) begin
            dir_q  <= DIR_HOLD;
            hold_q <= cfg_q[CFG_HOLD2] ? HOLD_TWO : HOLD_ONE;
          end
        end
        DIR_HOLD: begin
          if (tx_busy) begin
            dir_q <= DIR_SEND;
          end else if (bit_tick) begin
            hold_q <= hold_q - 2'h1;
            if (hold_q == HOLD_ONE) dir_q <= DIR_IDLE;
          end
        end
      endcase
    end
  end

  logic sending;
  assign sending = (dir_q != DIR_IDLE);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rts_out <= 1'b0;
    end else if (ce) begin
      rts_out <= auto_dir ? (sending ^ cfg_q[CFG_POL]) : rts_core;
    end
  end

  // Nine-bit status; a new event wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stat_q <= 1'b0;
    end else if (irq_evt) begin
      stat_q <= 1'b1;
    end else if (wr_hit(IDX_STAT)) begin
      stat_q <= pwdata[0];
    end
  end

  // Pulse mode lets several ports share one line by signalling edges only
  logic irq_src;
  assign irq_src = core_irq | (stat_q & irqc_q[IRQC_EN]);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_src_q <= 1'b0;
      port_irq  <= 1'b0;
    end else if (ce) begin
      irq_src_q <= irq_src;
      port_irq  <= misc_q[MISC_PULSE] ? (irq_src & ~irq_src_q) : irq_src;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_addr_in;
    ce && rx_valid && is_addr;
  endsequence
  sequence s_tx_end;
    ce && dir_q == DIR_SEND && !tx_busy;
  endsequence

  a_delay_sel: assert property (rx_clk_delay == !misc_q[MISC_NODELAY])
    else $error("receive clock delay select wrong");
  a_irq_pulse: assert property (ce && misc_q[MISC_PULSE] && port_irq |=> !port_irq)
    else $error("pulse-mode interrupt longer than one cycle");
  a_irq_level: assert property (ce && !misc_q[MISC_PULSE] && irq_src
                                |=> port_irq || !$past(ce))
    else $error("level interrupt not asserted");
  a_err_sel: assert property (ce && misc_q[MISC_NEWERR] && err_new |=> rx_err)
    else $error("revised error indication not selected");
  a_data_gate: assert property (ce && rx_valid && nine && cfg_q[CFG_AUTO_RX] && !accept_q
                                && !rx_char.ninth |=> !rxf_wr)
    else $error("data byte passed without acceptance");
  a_cmp_only: assert property (s_addr_in ##0 cfg_q[CFG_CMP_ONLY] && !wr_hit(IDX_TXRX)
                               |=> $stable(accept_q))
    else $error("accept flag changed in compare-only mode");
  a_accept_upd: assert property (s_addr_in ##0 cfg_q[CFG_AUTO_RX] && !cfg_q[CFG_CMP_ONLY]
                                 |=> accept_q == $past(match))
    else $error("accept flag not updated from match");
  a_hold_min: assert property (s_tx_end |=> dir_q == DIR_HOLD &&
                               hold_q == ($past(cfg_q[CFG_HOLD2]) ? HOLD_TWO : HOLD_ONE))
    else $error("direction hold time not loaded");
  a_rts_level: assert property (ce && $past(ce) && auto_dir && $past(auto_dir)
                                |-> rts_out == ($past(sending) ^ $past(cfg_q[CFG_POL])))
    else $error("RTS polarity wrong");
  a_addr_clear: assert property (ce && tx_done && tx_addr_q && cfg_q[CFG_AUTO_TX]
                                 |=> !send_addr_q)
    else $error("send-address flag not cleared");
  a_addr_drop: assert property (s_addr_in ##0 !cfg_q[CFG_STORE] |=> !rxf_wr)
    else $error("address byte stored while discard selected");
  a_normal_mode: assert property (ce && !nine |=> !tx_ninth_en)
    else $error("ninth bit used in normal mode");
  a_match_irq: assert property (s_addr_in ##0 cfg_q[CFG_AUTO_RX] && irqc_q == 2'h3 && !match
                                && !stat_q && !wr_hit(IDX_STAT) |=> !stat_q)
    else $error("status set on unmatched address");
  a_irq_gate: assert property (ce && !irqc_q[IRQC_EN] && !core_irq
                               && !misc_q[MISC_PULSE] |=> !port_irq)
    else $error("nine-bit interrupt not gated by enable");
  a_stat_set: assert property (irq_evt |=> stat_q)
    else $error("status not set by nine-bit interrupt");

endmodule

// >>> rtl/u9m_pkg.sv
// Constants, register map and carrier types for the nine-bit multidrop port control block.
// Assumes a single 25 MHz clock domain and an APB master with 32-bit data.
package u9m_pkg;
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned RX_DELAY_NS = 5;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_MISC  = 10'h0F0;
  localparam logic [9:0] IDX_TXRX  = 10'h0F1;
  localparam logic [9:0] IDX_CFG   = 10'h0F2;
  localparam logic [9:0] IDX_SLAVE = 10'h0F3;
  localparam logic [9:0] IDX_MASK  = 10'h0F4;
  localparam logic [9:0] IDX_BCAST = 10'h0F5;
  localparam logic [9:0] IDX_IRQC  = 10'h0F6;
  localparam logic [9:0] IDX_STAT  = 10'h0F7;

  localparam logic [7:0] RST_MISC  = 8'h00;
  localparam logic [7:0] RST_CFG   = 8'h00;
  localparam logic [7:0] RST_SLAVE = 8'h00;
  localparam logic [7:0] RST_MASK  = 8'hFF;
  localparam logic [7:0] RST_BCAST = 8'hFF;
  localparam logic [1:0] RST_IRQC  = 2'h2;

  // Misc control fields
  localparam int unsigned MISC_NODELAY = 7;
  localparam int unsigned MISC_PULSE   = 6;
  localparam int unsigned MISC_NEWERR  = 5;
  localparam logic [7:0]  MISC_WMASK   = 8'hE3;
  // Nine-bit config fields
  localparam int unsigned CFG_AUTO_RX  = 7;
  localparam int unsigned CFG_CMP_ONLY = 6;
  localparam int unsigned CFG_HOLD2    = 5;
  localparam int unsigned CFG_POL      = 4;
  localparam int unsigned CFG_AUTO_TX  = 3;
  localparam int unsigned CFG_STORE    = 2;
  localparam int unsigned CFG_RS485    = 1;
  localparam int unsigned CFG_NINE     = 0;
  // Interrupt control / status / tx-rx flag fields
  localparam int unsigned IRQC_MATCH   = 1;
  localparam int unsigned IRQC_EN      = 0;
  localparam int unsigned TXRX_SENDADR = 0;
  localparam int unsigned TXRX_ACCEPT  = 1;

  // Baud clock selections
  localparam logic [1:0] CLKSEL_DIV13  = 2'h0;
  localparam logic [1:0] CLKSEL_DIV12  = 2'h1;
  localparam logic [1:0] CLKSEL_DIV1   = 2'h2;
  localparam logic [1:0] CLKSEL_DIV1P6 = 2'h3;

  localparam logic [1:0] HOLD_ONE = 2'h1;
  localparam logic [1:0] HOLD_TWO = 2'h2;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } u9m_char_t;

  typedef enum logic [1:0] {DIR_IDLE, DIR_SEND, DIR_HOLD} u9m_dir_t;
endpackage

// >>> verification/u9m_ctrl_tb_top.sv
// Self-checking bench for the nine-bit multidrop control block.
// Assumes an APB slave that answers by pready, ce high except in the freeze check, and the node model.
module u9m_ctrl_tb_top
  import u9m_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        nrst, ce, psel, penable, pwrite, tx_start, tx_busy, tx_done;
  logic        bit_tick, rts_core, err_orig, err_new, core_irq, pready, pslverr;
  logic        rxf_wr, rx_valid, tx_ninth, tx_ninth_en, rts_out, rx_err, port_irq;
  logic        rx_clk_delay, er, acc, mt, st, adr, pol, h2;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [7:0]  s, m, b, d, cfg;
  logic [1:0]  baud_clk_sel, ic;
  u9m_char_t   rx_char, rxf_char;
  int          fail_count, compares, i, n;
  logic [9:0]  ri [6] = '{IDX_MISC, IDX_CFG, IDX_SLAVE, IDX_MASK, IDX_BCAST, IDX_IRQC};
  logic [7:0]  rv [6] = '{RST_MISC, RST_CFG, RST_SLAVE, RST_MASK, RST_BCAST, {6'h00, RST_IRQC}};

  always #20 clk_sys = ~clk_sys;

  u9m_ctrl uut (.clk_sys, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .rx_char, .rxf_char, .rxf_wr, .tx_start, .tx_busy,
    .tx_done, .bit_tick, .tx_ninth, .tx_ninth_en, .rts_core, .rts_out, .err_orig,
    .err_new, .rx_err, .core_irq, .port_irq, .rx_clk_delay, .baud_clk_sel);
  u9m_node node (.clk_sys, .rx_char, .rx_valid);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("mismatches=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One APB transfer; the bound on the wait is the only hang guard needed
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 16) begin
      fail_count++;
      results();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  // Resumes at an edge: reads see the values settled before it, drives land on it
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  task automatic tk(input int c);
    repeat (c) begin
      bit_tick <= 1'b1;
      cyc(1);
      bit_tick <= 1'b0;
      cyc(3);
    end
  endtask

  function automatic logic match(input logic [7:0] a, sa, ma, ba);
    return (a == ba) || (((a ^ sa) & ma) == 8'h00);
  endfunction

  initial begin
    {nrst, psel, penable, pwrite, tx_start, tx_busy, tx_done, bit_tick} = '0;
    {rts_core, err_orig, err_new, core_irq} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    fail_count = 0;
    compares = 0;
    void'($urandom(32'hCF0F));
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    for (i = 0; i < 6; i++) rdc(ri[i], {24'h0, rv[i]});
    for (i = 2; i < 5; i++) begin
      v = {24'h0, 8'($urandom)};
      wr(ri[i], v);
      rdc(ri[i], v);
    end
    apb(1'b0, 10'h0F8, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (i = 0; i < 8; i++) begin
      v = {24'h0, 8'($urandom)};
      v[1:0] = i[1:0];
      wr(IDX_MISC, v);
      err_orig <= 1'($urandom);
      err_new  <= 1'($urandom);
      cyc(3);
      chk(baud_clk_sel, v[1:0]);
      chk(rx_clk_delay, !v[7]);
      chk(rx_err, v[5] ? err_new : err_orig);
      rdc(IDX_MISC, v & {24'h0, MISC_WMASK});
    end
    wr(IDX_MISC, 32'h0);
    core_irq <= 1'b1;
    cyc(3);
    chk(port_irq, 1'b1);
    core_irq <= 1'b0;
    cyc(3);
    chk(port_irq, 1'b0);
    wr(IDX_MISC, 32'h40);
    core_irq <= 1'b1;
    n = 0;
    repeat (6) begin
      cyc(1);
      if (port_irq !== 1'b0) n++;
    end
    chk(n, 1);
    core_irq <= 1'b0;
    wr(IDX_MISC, 32'h0);
    for (i = 0; i < 14; i++) begin
      cfg = (i == 0) ? 8'h85 : 8'($urandom) & 8'hC5;
      ic = (i == 0) ? 2'h3 : 2'($urandom);
      s = 8'($urandom);
      m = 8'($urandom);
      b = 8'($urandom);
      d = (i % 3 == 0) ? b : (i % 3 == 1) ? (s ^ (~m & 8'($urandom))) : 8'($urandom);
      wr(IDX_CFG, cfg);
      wr(IDX_SLAVE, s);
      wr(IDX_MASK, m);
      wr(IDX_BCAST, b);
      wr(IDX_IRQC, ic);
      wr(IDX_STAT, 32'h0);
      wr(IDX_TXRX, 32'h0);
      acc = 1'b0;
      adr = cfg[CFG_NINE];
      node.send(1'b1, d, $urandom % 3);
      #1;
      chk(rxf_wr, !adr || cfg[CFG_STORE]);
      if (rxf_wr === 1'b1) chk(rxf_char, {1'b1, d});
      mt = match(d, s, m, b);
      if (adr && cfg[CFG_AUTO_RX] && !cfg[CFG_CMP_ONLY]) acc = mt;
      st = adr & cfg[CFG_AUTO_RX] & ic[0] & (mt | !ic[1]);
      node.send(1'b0, 8'($urandom), $urandom % 3);
      #1;
      chk(rxf_wr, !(adr && cfg[CFG_AUTO_RX] && !acc));
      cyc(2);
      chk(port_irq, st);
      rdc(IDX_STAT, st);
      rdc(IDX_TXRX, {acc, 1'b0});
      wr(IDX_IRQC, {30'h0, ic[1], 1'b0});
      cyc(2);
      chk(port_irq, 1'b0);
    end
    for (i = 0; i < 4; i++) begin
      pol = i[0];
      h2 = i[1];
      wr(IDX_CFG, {2'b00, h2, pol, 4'h3});
      cyc(2);
      chk(rts_out, pol);
      tx_busy <= 1'b1;
      cyc(3);
      chk(rts_out, !pol);
      tx_busy <= 1'b0;
      cyc(3);
      chk(rts_out, !pol);
      tk(1);
      chk(rts_out, h2 ? !pol : pol);
      tk(2);
      chk(rts_out, pol);
    end
    wr(IDX_CFG, 32'h0);
    rts_core <= 1'b1;
    cyc(3);
    chk(rts_out, 1'b1);
    for (i = 0; i < 2; i++) begin
      wr(IDX_CFG, {28'h0, i[0], 3'h1});
      wr(IDX_TXRX, 32'h1);
      cyc(2);
      chk({tx_ninth_en, tx_ninth}, 2'h3);
      tx_start <= 1'b1;
      tx_busy  <= 1'b1;
      cyc(1);
      tx_start <= 1'b0;
      cyc(4);
      tx_busy <= 1'b0;
      tx_done <= 1'b1;
      cyc(1);
      tx_done <= 1'b0;
      cyc(2);
      rdc(IDX_TXRX, {31'h0, !i[0]});
    end
    wr(IDX_CFG, 32'h0);
    cyc(2);
    chk({tx_ninth_en, tx_ninth}, 2'h0);
    // A low clock enable must freeze the interrupt line
    ce <= 1'b0;
    core_irq <= 1'b1;
    cyc(3);
    chk(port_irq, 1'b0);
    ce <= 1'b1;
    cyc(3);
    chk(port_irq, 1'b1);
    core_irq <= 1'b0;
    results();
  end
endmodule

// >>> verification/u9m_node.sv
// Remote multidrop node model on the receive side of the control block.
// Assumes one caller at a time; the caller resumes at the edge that samples the strobe.
module u9m_node
  import u9m_pkg::*;
(
  input  wire logic clk_sys,  // Block clock
  output u9m_char_t rx_char,  // Framed character
  output logic      rx_valid  // One-cycle character strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid = 1'b0;
    rx_char  = '0;
  end
  // Gap lets the node answer promptly or slowly
  task automatic send(input logic adr, input logic [7:0] d, input int gap);
    u9m_char_t c;
    c = '{ninth: adr, data: d};
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_char  <= c;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    // A released line must not keep showing the old character
    rx_char  <= ~c;
  endtask
endmodule
